// file: verilog/epdsh_defs.svh
// Constants of the e-paper serial host port
`ifndef EPDSH_DEFS_SVH
`define EPDSH_DEFS_SVH

`define EPDSH_BITS_4W      4'h8
`define EPDSH_BITS_3W      4'h9
`define EPDSH_CNT_ZERO     4'h0
`define EPDSH_CNT_ONE      4'h1
// Synchroniser idle: select high, clock and data low, reset pin high
`define EPDSH_SYNC_IDLE    6'h09
`define EPDSH_RD_CMD_A     8'h1b
`define EPDSH_RD_CMD_B     8'h27
`define EPDSH_RD_CMD_C     8'h2d
`define EPDSH_RD_CMD_D     8'h2e
`define EPDSH_RD_CMD_E     8'h2f
`define EPDSH_RD_CMD_F     8'h35
`define EPDSH_FIFO_WIDTH   8
`define EPDSH_FIFO_DEPTH   32

`endif

// file: verilog/epdsh_pkg.sv
// Types of the e-paper serial host port
package epdsh_pkg;

  typedef enum logic [1:0]
  {
    EPDSH_MODE_4W = 2'h1,
    EPDSH_MODE_3W = 2'h2
  } epdsh_mode_t;

  typedef enum logic [2:0]
  {
    EPDSH_ST_IDLE  = 3'h1,
    EPDSH_ST_WRITE = 3'h2,
    EPDSH_ST_READ  = 3'h4
  } epdsh_state_t;

endpackage

// file: verilog/epdsh_fifo_if.sv
// Valid/ready carrier between the port and its data FIFO
`timescale 1ns/1ps
`include "epdsh_defs.svh"

interface epdsh_fifo_if;
  logic                          in_valid;
  logic                          in_ready;
  logic [`EPDSH_FIFO_WIDTH-1:0]  in_data;
  logic                          out_valid;
  logic                          out_ready;
  logic [`EPDSH_FIFO_WIDTH-1:0]  out_data;

  modport fifo
  (
    input  in_valid,
    output in_ready,
    input  in_data,
    output out_valid,
    input  out_ready,
    output out_data
  );

  modport user
  (
    output in_valid,
    input  in_ready,
    output in_data,
    input  out_valid,
    output out_ready,
    input  out_data
  );
endinterface

// file: verilog/epdsh_fifo.sv
// Data FIFO with registered read data
`timescale 1ns/1ps
`include "epdsh_defs.svh"

module epdsh_fifo
#(
  parameter int WIDTH = `EPDSH_FIFO_WIDTH,
  parameter int DEPTH = `EPDSH_FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic  clk,
  input wire logic  rst,
  // Stream ports
  epdsh_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    wp_d;
  logic [AW-1:0]    rp_q;
  logic [AW-1:0]    rp_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             ov_q;
  logic             ov_d;
  logic [WIDTH-1:0] od_q;
  logic [WIDTH-1:0] od_d;
  logic             wr;
  logic             pop;

  assign f.in_ready  = (cnt_q != FULL);
  assign f.out_valid = ov_q;
  assign f.out_data  = od_q;

  always_comb
  begin
    wr    = f.in_valid & f.in_ready;
    // Output register refills as soon as it empties or is taken
    pop   = (~ov_q | f.out_ready) & (cnt_q != '0);
    wp_d  = wr ? wp_q + AW'(1'b1) : wp_q;
    rp_d  = pop ? rp_q + AW'(1'b1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(pop);
    od_d  = pop ? mem[rp_q] : od_q;
    ov_d  = pop ? 1'b1 : (f.out_ready ? 1'b0 : ov_q);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      ov_q  <= 1'b0;
      od_q  <= '0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      ov_q  <= ov_d;
      od_q  <= od_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (wr)
      mem[wp_q] <= f.in_data;
  end
endmodule

// file: verilog/epdsh_port.sv
// Serial host port of the e-paper display controller
//
// Summary of operation
// [R1] Strap low four-wire, high three-wire nine-bit
// [R2] Four-wire: shift eight bits MSB first rising
// [R3] Four-wire: pin level routes byte command/data
// [R4] Host holds data/command level whole byte
// [R5] Only six listed commands open read phase
// [R6] Host reads: command low, then data high
// [R7] Read bytes driven MSB first on falling
// [R8] Three-wire: host ties data/command pin low
// [R9] Three-wire: flag then eight bits rising
// [R10] Flag zero command, flag one data
// [R11] Three-wire read: device drives after flag one
// [R12] Host adds full refresh after five fast
// [R13] Chip select high clears counter, drops unit
`timescale 1ns/1ps
`include "epdsh_defs.svh"

module epdsh_port
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Host pins
  input  wire logic        hard_reset_n,
  input  wire logic        interface_select,
  input  wire logic        chip_select_n,
  input  wire logic        data_command_select,
  input  wire logic        serial_clock_line,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Command stream to the core
  output logic             cmd_valid,
  output logic [7:0]       cmd_byte,
  // Write data stream to the core
  output logic             data_valid,
  output logic [7:0]       data_byte,
  input  wire logic        data_ready,
  output logic             data_room,
  output logic             data_overflow,
  // Read data from the core
  input  wire logic [7:0]  rd_byte,
  output logic             rd_req,
  // Status
  output logic             three_wire,
  output logic             read_phase
);

  // Two-stage synchronisers for every pin
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic       scl_prev_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // Idle levels keep a false select or clock edge off the link after reset
      s1_q       <= `EPDSH_SYNC_IDLE;
      s2_q       <= `EPDSH_SYNC_IDLE;
      scl_prev_q <= 1'b0;
    end
    else
    begin
      s1_q       <= {serial_clock_line, sda_in, chip_select_n,
                     data_command_select, interface_select, hard_reset_n};
      s2_q       <= s1_q;
      scl_prev_q <= s2_q[5];
    end
  end

  logic scl_s;
  logic sda_s;
  logic csn_s;
  logic dc_s;
  logic sel_s;
  logic hrn_s;
  logic rise;
  logic fall;
  logic link_rst;

  assign scl_s    = s2_q[5];
  assign sda_s    = s2_q[4];
  assign csn_s    = s2_q[3];
  assign dc_s     = s2_q[2];
  assign sel_s    = s2_q[1];
  assign hrn_s    = s2_q[0];
  assign rise     = scl_s & ~scl_prev_q;
  assign fall     = ~scl_s & scl_prev_q;
  // Display reset pin clears the link like the system reset
  assign link_rst = rst | ~hrn_s;

  function automatic logic is_read_cmd(input logic [7:0] c);
    is_read_cmd = (c == `EPDSH_RD_CMD_A) || (c == `EPDSH_RD_CMD_B) ||
                  (c == `EPDSH_RD_CMD_C) || (c == `EPDSH_RD_CMD_D) ||
                  (c == `EPDSH_RD_CMD_E) || (c == `EPDSH_RD_CMD_F);
  endfunction

  function automatic logic [3:0] unit_bits(input epdsh_pkg::epdsh_mode_t m);
    unit_bits = (m == epdsh_pkg::EPDSH_MODE_3W) ? `EPDSH_BITS_3W : `EPDSH_BITS_4W;
  endfunction

  // FIFO on the write data path
  epdsh_fifo_if fq ();

  epdsh_fifo
  #(
    .WIDTH (`EPDSH_FIFO_WIDTH),
    .DEPTH (`EPDSH_FIFO_DEPTH)
  )
  u_fifo
  (
    .clk (clk),
    .rst (link_rst),
    .f   (fq)
  );

  epdsh_pkg::epdsh_mode_t  mode_q;
  epdsh_pkg::epdsh_mode_t  mode_d;
  epdsh_pkg::epdsh_state_t st_q;
  epdsh_pkg::epdsh_state_t st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [8:0] shin_q;
  logic [8:0] shin_d;
  logic       flag_q;
  logic       flag_d;
  logic [7:0] shout_q;
  logic [7:0] shout_d;
  logic       sdo_q;
  logic       sdo_d;
  logic       oe_q;
  logic       oe_d;
  logic       cmdv_q;
  logic       cmdv_d;
  logic [7:0] cmdb_q;
  logic [7:0] cmdb_d;
  logic       push_q;
  logic       push_d;
  logic [7:0] pushb_q;
  logic [7:0] pushb_d;
  logic       ovf_q;
  logic       ovf_d;
  logic       rdq_q;
  logic       rdq_d;
  logic [7:0] unit_byte;
  logic       unit_data;
  logic       rd_start;

  always_comb
  begin
    mode_d    = mode_q;
    st_d      = st_q;
    cnt_d     = cnt_q;
    shin_d    = shin_q;
    flag_d    = flag_q;
    shout_d   = shout_q;
    sdo_d     = sdo_q;
    oe_d      = oe_q;
    cmdv_d    = 1'b0;
    cmdb_d    = cmdb_q;
    push_d    = push_q & ~fq.in_ready;
    pushb_d   = pushb_q;
    ovf_d     = 1'b0;
    rdq_d     = 1'b0;
    unit_byte = {shin_q[6:0], sda_s};
    // Three-wire flag sits one place above the byte before the last shift
    unit_data = (mode_q == epdsh_pkg::EPDSH_MODE_3W) ? shin_q[7] : dc_s; // [R3] [R10]
    rd_start  = (mode_q == epdsh_pkg::EPDSH_MODE_3W) ?
                (cnt_q == `EPDSH_CNT_ONE) && flag_q :
                (cnt_q == `EPDSH_CNT_ZERO) && dc_s;
    if (csn_s)
    begin
      // Idle: drop any partial unit and follow the strap
      cnt_d  = `EPDSH_CNT_ZERO; // [R13]
      shin_d = '0; // [R13]
      st_d   = epdsh_pkg::EPDSH_ST_IDLE;
      oe_d   = 1'b0;
      mode_d = sel_s ? epdsh_pkg::EPDSH_MODE_3W : epdsh_pkg::EPDSH_MODE_4W; // [R1]
    end
    else
    begin
      if (rise)
      begin
        shin_d = {shin_q[7:0], sda_s}; // [R2] [R9]
        cnt_d  = cnt_q + 4'h1;
        if ((mode_q == epdsh_pkg::EPDSH_MODE_3W) && (cnt_q == `EPDSH_CNT_ZERO))
          flag_d = sda_s; // [R9]
        if (cnt_q + 4'h1 == unit_bits(mode_q)) // [R1]
        begin
          cnt_d = `EPDSH_CNT_ZERO;
          if (!unit_data)
          begin
            cmdv_d = 1'b1; // [R3] [R10]
            cmdb_d = unit_byte;
            st_d   = is_read_cmd(unit_byte) ? epdsh_pkg::EPDSH_ST_READ // [R5]
                                            : epdsh_pkg::EPDSH_ST_WRITE;
          end
          else
          begin
            case (st_q)
              // Units of a read phase only clock the reply out
              epdsh_pkg::EPDSH_ST_READ:
                ovf_d = 1'b0;
              default:
              begin
                // A full FIFO cannot stall the host clock, so the byte is lost
                if (fq.in_ready && !push_q)
                begin
                  push_d  = 1'b1; // [R3]
                  pushb_d = unit_byte;
                end
                else
                  ovf_d = 1'b1;
              end
            endcase
          end
        end
      end
      if (fall)
      begin
        case (st_q)
          epdsh_pkg::EPDSH_ST_READ:
          begin
            if (rd_start)
            begin
              sdo_d   = rd_byte[7]; // [R7] [R11]
              shout_d = {rd_byte[6:0], 1'b0};
              oe_d    = 1'b1;
              rdq_d   = 1'b1;
            end
            else if (cnt_q == `EPDSH_CNT_ZERO)
              oe_d = 1'b0; // [R11]
            else if (oe_q)
            begin
              sdo_d   = shout_q[7]; // [R7]
              shout_d = {shout_q[6:0], 1'b0};
            end
          end
          // The line is never driven outside a read
          default:
            oe_d = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (link_rst)
    begin
      mode_q  <= epdsh_pkg::EPDSH_MODE_4W;
      st_q    <= epdsh_pkg::EPDSH_ST_IDLE;
      cnt_q   <= `EPDSH_CNT_ZERO;
      shin_q  <= '0;
      flag_q  <= 1'b0;
      shout_q <= '0;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
      cmdv_q  <= 1'b0;
      cmdb_q  <= '0;
      push_q  <= 1'b0;
      pushb_q <= '0;
      ovf_q   <= 1'b0;
      rdq_q   <= 1'b0;
    end
    else
    begin
      mode_q  <= mode_d;
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      shin_q  <= shin_d;
      flag_q  <= flag_d;
      shout_q <= shout_d;
      sdo_q   <= sdo_d;
      oe_q    <= oe_d;
      cmdv_q  <= cmdv_d;
      cmdb_q  <= cmdb_d;
      push_q  <= push_d;
      pushb_q <= pushb_d;
      ovf_q   <= ovf_d;
      rdq_q   <= rdq_d;
    end
  end

  assign fq.in_valid    = push_q;
  assign fq.in_data     = pushb_q;
  assign fq.out_ready   = data_ready;
  assign data_valid     = fq.out_valid;
  assign data_byte      = fq.out_data;
  assign data_room      = fq.in_ready;
  assign data_overflow  = ovf_q;
  assign sda_out        = sdo_q;
  assign sda_oe         = oe_q;
  assign cmd_valid      = cmdv_q;
  assign cmd_byte       = cmdb_q;
  assign rd_req         = rdq_q;
  assign three_wire     = (mode_q == epdsh_pkg::EPDSH_MODE_3W);
  assign read_phase     = (st_q == epdsh_pkg::EPDSH_ST_READ);

endmodule

// file: tb/epdsh_port_properties.sv
// Port-level checks on the serial host port
`timescale 1ns/1ps
module epdsh_port_properties
(
  // Clock and resets
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       hard_reset_n,
  // Pins
  input wire logic       interface_select,
  input wire logic       chip_select_n,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Core side
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic       data_valid,
  input wire logic       data_room,
  input wire logic [7:0] rd_byte,
  input wire logic       rd_req,
  input wire logic       three_wire,
  input wire logic       read_phase
);
  logic rd_msb;
  logic rd_cmd;
  assign rd_msb = rd_byte[7];
  assign rd_cmd = cmd_byte inside {8'h1b, 8'h27, 8'h2d, 8'h2e, 8'h2f, 8'h35};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || !hard_reset_n);
  // Long enough for the pin synchronisers to flush
  sequence s_cs_idle;
    chip_select_n [*4];
  endsequence
  sequence s_strap_held;
    (chip_select_n && $stable(interface_select)) [*6];
  endsequence
  chk_strap_mode: assert property (s_strap_held |-> three_wire == interface_select)
    else $error("mode differs from strap");
  chk_cs_idle: assert property (s_cs_idle |-> !read_phase && !sda_oe)
    else $error("read state kept with select high");
  chk_oe_read: assert property ($rose(sda_oe) |-> read_phase)
    else $error("data driven outside read");
  chk_rd_first: assert property (rd_req |-> sda_oe && sda_out == $past(rd_msb))
    else $error("read byte not led by top bit");
  chk_read_list: assert property ($rose(read_phase) |-> rd_cmd)
    else $error("read after unlisted command");
  chk_read_end: assert property (cmd_valid && !rd_cmd |-> ##1 !read_phase [*2])
    else $error("read kept after unlisted command");
  chk_cmd_gap: assert property (cmd_valid |=> !cmd_valid [*8])
    else $error("command strobes too close");
  chk_full_head: assert property (!data_room |-> data_valid)
    else $error("full buffer without head");
endmodule
bind epdsh_port epdsh_port_properties chk (.*);

// file: tb/epdsh_host_model.sv
// Host controller model that drives the serial pins
`timescale 1ns/1ps
module epdsh_host_model
(
  // Clock, strap and shared data line
  input wire logic clk,
  input wire logic interface_select,
  input wire logic sda_in,
  // Serial pins
  output logic     chip_select_n,
  output logic     data_command_select,
  output logic     serial_clock_line,
  output logic     host_sda
);
  initial
  begin
    chip_select_n = 1'b1;
    data_command_select = 1'b0;
    serial_clock_line = 1'b0;
    host_sda = 1'b0;
  end
  // Five low and three high cycles give 320 ns; clock rests between units
  task automatic unit(input logic [8:0] u, input int n, input logic dc, output logic [7:0] rx);
    rx = 8'h00;
    chip_select_n <= 1'b0;
    data_command_select <= dc & !interface_select;
    repeat (3) @(posedge clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_clock_line <= 1'b0;
      host_sda <= u[i];
      repeat (5) @(posedge clk);
      serial_clock_line <= 1'b1;
      // Host reads the shared line, so a reply without enable is caught
      rx = {rx[6:0], sda_in};
      repeat (3) @(posedge clk);
    end
  endtask
  // Select rises first so the clock drop is never taken as a read drive edge
  task automatic stop();
    chip_select_n <= 1'b1;
    repeat (2) @(posedge clk);
    serial_clock_line <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule

// file: tb/epaper_serial_host_port_test.sv
// Self-checking bench for the serial host port
`timescale 1ns/1ps
module epaper_serial_host_port_test;
  logic       clk, rst, hard_reset_n, data_ready, interface_select;
  logic       chip_select_n, data_command_select, serial_clock_line, host_sda;
  logic       sda_out, sda_oe, cmd_valid, data_valid, data_room, data_overflow;
  logic       rd_req, three_wire, read_phase;
  logic [7:0] rd_byte, cmd_byte, data_byte, rx;
  logic [7:0] got[$];
  int         fail_count, n_tests, n_cmd, n_ovf, cycles;
  // Device owns the line while enabled; otherwise the host pattern shows
  wire        sda_in = sda_oe ? sda_out : host_sda;

  epdsh_port dut (.*);
  epdsh_host_model host (.*);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cmd_valid)
      n_cmd <= n_cmd + 1;
    if (data_overflow)
      n_ovf <= n_ovf + 1;
    if (data_valid && data_ready)
      got.push_back(data_byte);
    if (cycles == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic t_write4();
    int c;
    c = n_cmd;
    got.delete();
    host.unit(9'h012, 8, 1'b0, rx);
    host.unit(9'h0a5, 8, 1'b1, rx);
    host.stop();
    check("cmds", 8'(n_cmd - c), 8'h01);
    check("cmd", cmd_byte, 8'h12);
    check("data", got[0], 8'ha5);
  endtask

  task automatic t_read4();
    logic [7:0] cmds [6] = '{8'h1b, 8'h27, 8'h2d, 8'h2e, 8'h2f, 8'h35};
    foreach (cmds[i])
    begin
      rd_byte <= cmds[i] ^ 8'h5a;
      host.unit({1'b0, cmds[i]}, 8, 1'b0, rx);
      repeat (4) @(posedge clk);
      check("read phase", {7'h00, read_phase}, 8'h01);
      for (int k = 0; k < 2; k++)
      begin
        host.unit(9'h0aa, 8, 1'b1, rx);
        check("read byte", rx, cmds[i] ^ 8'h5a);
      end
      host.unit(9'h020, 8, 1'b0, rx);
      repeat (4) @(posedge clk);
      check("read end", {7'h00, read_phase}, 8'h00);
      host.stop();
    end
  endtask

  task automatic t_partial();
    int c;
    c = n_cmd;
    host.unit(9'h0ff, 5, 1'b0, rx);
    host.stop();
    host.unit(9'h081, 8, 1'b0, rx);
    host.stop();
    check("cmds", 8'(n_cmd - c), 8'h01);
    check("cmd", cmd_byte, 8'h81);
  endtask

  task automatic t_hard();
    host.unit(9'h01b, 8, 1'b0, rx);
    hard_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    check("reset read", {7'h00, read_phase}, 8'h00);
    check("reset room", {7'h00, data_room}, 8'h01);
    hard_reset_n <= 1'b1;
    host.stop();
  endtask

  task automatic t_three();
    interface_select <= 1'b1;
    repeat (8) @(posedge clk);
    check("mode", {7'h00, three_wire}, 8'h01);
    got.delete();
    rd_byte <= 8'h96;
    host.unit(9'h02f, 9, 1'b1, rx);
    host.unit(9'h1aa, 9, 1'b1, rx);
    check("read 3w", rx, 8'h96);
    host.unit(9'h040, 9, 1'b0, rx);
    host.unit(9'h13c, 9, 1'b0, rx);
    host.stop();
    check("cmd 3w", cmd_byte, 8'h40);
    check("data 3w", got[0], 8'h3c);
    interface_select <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // Consumer stalls while 34 bytes arrive; one more than the buffer holds
  task automatic t_fill();
    data_ready <= 1'b0;
    got.delete();
    for (int i = 0; i < 34; i++)
      host.unit({1'b0, 8'(i)}, 8, 1'b1, rx);
    host.stop();
    check("room", {7'h00, data_room}, 8'h00);
    check("overflows", 8'(n_ovf), 8'h01);
    data_ready <= 1'b1;
    repeat (40) @(posedge clk);
    check("drained", 8'(got.size()), 8'h21);
    foreach (got[i])
      check("order", got[i], 8'(i));
  endtask

  initial
  begin
    rst = 1'b1;
    hard_reset_n = 1'b1;
    data_ready = 1'b1;
    interface_select = 1'b0;
    rd_byte = 8'h00;
    fail_count = 0;
    n_tests = 0;
    n_cmd = 0;
    n_ovf = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    t_write4();
    t_read4();
    t_partial();
    t_hard();
    t_three();
    t_fill();
    end_of_test();
  end
endmodule
